/* rtl/iav_regs.svh */
// Purpose: named constants of the usb and fifo interrupt autovector block
// Assumes: 8-bit vector bytes, 16-bit core code addresses
// Notes:   definitions only
`ifndef IAV_REGS_SVH
`define IAV_REGS_SVH

// slot counts; usb slots include the five reserved ones
`define IAV_USB_SLOTS       32
`define IAV_USB_SLOT_W      5
`define IAV_FIFO_SLOTS      14
`define IAV_FIFO_SLOT_W     4

// slots that carry no source on the usb line
`define IAV_USB_RSVD_MASK   32'h0E02_0080

// vector byte bases
`define IAV_USB_VEC_BASE    8'h00
`define IAV_FIFO_VEC_BASE   8'h80
`define IAV_VEC_RESET       8'h00

// jump slots and substituted locations in code space
`define IAV_USB_JUMP_ADDR   16'h0043
`define IAV_USB_PAGE_ADDR   16'h0044
`define IAV_USB_VEC_ADDR    16'h0045
`define IAV_FIFO_JUMP_ADDR  16'h0053
`define IAV_FIFO_PAGE_ADDR  16'h0054
`define IAV_FIFO_VEC_ADDR   16'h0055

`define IAV_ADDR_RESET      16'h0000
`define IAV_BYTE_RESET      8'h00

`endif

/* rtl/iav_pkg.sv */
// Purpose: types of the interrupt autovector block
// Assumes: nothing
// Notes:   constants live in iav_regs.svh
`default_nettype none

package iav_pkg;

  // interrupt entry sequence toward the core
  typedef enum logic [2:0] {
    ENTRY_IDLE,
    ENTRY_PUSH_LO,
    ENTRY_PUSH_HI,
    ENTRY_BRANCH,
    ENTRY_SERVICE
  } iav_entry_t;

  // which shared line is being entered
  typedef enum logic {
    LINE_USB,
    LINE_FIFO
  } iav_line_t;

endpackage : iav_pkg

`default_nettype wire

/* rtl/iav_prio_enc.sv */
// Purpose: fixed priority encoder, lowest index wins
// Assumes: req is a plain level vector from the same clock
// Notes:   purely combinational; the caller registers the result
`default_nettype none

module iav_prio_enc #(
  parameter int N = 32,
  parameter int W = 5
) (
  // request side
  input  wire logic [N-1:0] req,
  // result side
  output logic              found,
  output logic [W-1:0]      index
);

  logic [N:0]   below;
  logic [N-1:0] grant;

  assign below[0] = 1'b0;

  // one-hot grant: a slot wins only if nothing of lower number asks
  for (genvar i = 0; i < N; i++) begin : g_chain
    assign grant[i]   = req[i] & ~below[i];
    assign below[i+1] = below[i] | req[i];
  end

  assign found = below[N];

  always_comb begin
    index = '0;
    for (int i = 0; i < N; i++) begin
      if (grant[i]) begin
        index = W'(i);
      end
    end
  end

endmodule : iav_prio_enc

`default_nettype wire

/* rtl/iav_autovector.sv */
// Purpose: second-level interrupt vectoring for the usb and fifo shared lines
// Assumes: event inputs come from logic on the same clock; no synchronisers
// Notes:   vector bytes are registered, so a fetch sees them one cycle late
//
// What this block does
// - twenty-seven usb event sources merge onto one usb interrupt request.
// - vectors 00..14 for setup data, frame, setup token, suspend, bus reset, high speed.
// - control handshake acked uses vector 18 at priority 7; 1C stays unused.
// - ep0 in, ep0 out, ep1 in, ep1 out map to vectors 20, 24, 28, 2C.
// - endpoints 2, 4, 6, 8 buffer events map to vectors 30, 34, 38, 3C.
// - in bulk nak raises vector 40 at priority 17; 44 never produced.
// - ping nak on out endpoints 0,1,2,4,6,8 raises vectors 48 through 5C.
// - bus error limit raises vector 60; 64, 68, 6C carry no source.
// - iso pid errors on endpoints 2,4,6,8 raise vectors 70 through 7C.
// - with usb autovector enabled, fetches of 0x0045 return the usb vector byte.
// - usb interrupt entry pushes the program counter and branches to 0x0043.
// - fourteen fifo and waveform engine sources merge onto a second request.
// - programmable level flags of endpoints 2,4,6,8 use vectors 80..8C.
// - empty flags of endpoints 2,4,6,8 use vectors 90..9C, priorities 5-8.
// - full flags of endpoints 2,4,6,8 use vectors A0..AC, priorities 9-12.
// - with fifo autovector enabled, fetches of 0x0055 return the fifo vector.
// - fifo interrupt entry pushes the program counter and branches to 0x0053.
`include "iav_regs.svh"
`default_nettype none

module iav_autovector (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,

  // usb event pulses, one cycle each
  input  wire logic        setup_data_available,
  input  wire logic        start_of_frame,
  input  wire logic        setup_token_seen,
  input  wire logic        usb_suspend,
  input  wire logic        usb_bus_reset,
  input  wire logic        high_speed_entered,
  input  wire logic        control_handshake_acked,
  input  wire logic        ep0_in_ready,
  input  wire logic        ep0_out_data,
  input  wire logic        ep1_in_ready,
  input  wire logic        ep1_out_data,
  input  wire logic [3:0]  ep_buffer_event,
  input  wire logic        in_bulk_nak,
  input  wire logic [5:0]  ep_ping_nak,
  input  wire logic        bus_error_limit,
  input  wire logic [3:0]  ep_iso_pid_error,

  // fifo flag levels and waveform engine pulses
  input  wire logic [3:0]  ep_prog_level_flag,
  input  wire logic [3:0]  ep_empty_flag,
  input  wire logic [3:0]  ep_full_flag,
  input  wire logic        waveform_op_complete,
  input  wire logic        waveform_event,

  // interrupt setup bits and per-source enables
  input  wire logic        usb_autovector_enable,
  input  wire logic        fifo_autovector_enable,
  input  wire logic [31:0] usb_source_enable,
  input  wire logic [13:0] fifo_source_enable,

  // pending clears from firmware
  input  wire logic        usb_clear,
  input  wire logic [4:0]  usb_clear_slot,
  input  wire logic        fifo_clear,
  input  wire logic [3:0]  fifo_clear_slot,

  // code fetch path
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  input  wire logic [7:0]  mem_rdata,
  output logic             fetch_data_valid,
  output logic [7:0]       fetch_data,

  // interrupt entry handshake with the core
  input  wire logic        core_take_ok,
  input  wire logic [15:0] core_pc,
  input  wire logic        core_reti,
  output logic             stack_push,
  output logic [7:0]       stack_push_byte,
  output logic             branch_valid,
  output logic [15:0]      branch_target,
  output logic             in_service,

  // line status
  output logic             usb_int_request,
  output logic             fifo_int_request,
  output logic [7:0]       usb_vector_byte,
  output logic [7:0]       fifo_vector_byte,
  output logic [31:0]      usb_pending,
  output logic [13:0]      fifo_pending
);

  // usb events placed at their vector slot; reserved slots are tied low
  logic [31:0] usb_slot_event;

  always_comb begin
    usb_slot_event      = '0;
    usb_slot_event[0]   = setup_data_available;
    usb_slot_event[1]   = start_of_frame;
    usb_slot_event[2]   = setup_token_seen;
    usb_slot_event[3]   = usb_suspend;
    usb_slot_event[4]   = usb_bus_reset;
    usb_slot_event[5]   = high_speed_entered;
    usb_slot_event[6]   = control_handshake_acked;
    usb_slot_event[8]   = ep0_in_ready;
    usb_slot_event[9]   = ep0_out_data;
    usb_slot_event[10]  = ep1_in_ready;
    usb_slot_event[11]  = ep1_out_data;
    usb_slot_event[15:12] = ep_buffer_event;
    usb_slot_event[16]  = in_bulk_nak;
    usb_slot_event[23:18] = ep_ping_nak;
    usb_slot_event[24]  = bus_error_limit;
    usb_slot_event[31:28] = ep_iso_pid_error;
  end

  // fifo flags are levels; only their rising edge asks for service
  logic [13:0] fifo_level_reg;
  logic [13:0] fifo_level_now;
  logic [13:0] fifo_slot_event;

  assign fifo_level_now = {2'b00, ep_full_flag, ep_empty_flag, ep_prog_level_flag};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fifo_level_reg <= '0;
    end else begin
      fifo_level_reg <= fifo_level_now;
    end
  end

  always_comb begin
    fifo_slot_event        = fifo_level_now & ~fifo_level_reg;
    fifo_slot_event[12]    = waveform_op_complete;
    fifo_slot_event[13]    = waveform_event;
  end

  // sticky pending bits; a new event in the clearing cycle survives
  logic [31:0] usb_clear_mask;
  logic [13:0] fifo_clear_mask;
  logic [31:0] usb_pending_next;
  logic [13:0] fifo_pending_next;

  always_comb begin
    usb_clear_mask  = '0;
    fifo_clear_mask = '0;
    if (usb_clear) begin
      usb_clear_mask[usb_clear_slot] = 1'b1;
    end
    if (fifo_clear) begin
      fifo_clear_mask[fifo_clear_slot] = 1'b1;
    end
  end

  assign usb_pending_next  = ((usb_pending & ~usb_clear_mask) | usb_slot_event)
                             & ~`IAV_USB_RSVD_MASK;
  assign fifo_pending_next = (fifo_pending & ~fifo_clear_mask) | fifo_slot_event;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      usb_pending <= '0;
    end else begin
      usb_pending <= usb_pending_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fifo_pending <= '0;
    end else begin
      fifo_pending <= fifo_pending_next;
    end
  end

  // enabled pending sources compete for the vector
  logic [31:0] usb_live;
  logic [13:0] fifo_live;
  logic        usb_found;
  logic        fifo_found;
  logic [4:0]  usb_top_slot;
  logic [3:0]  fifo_top_slot;

  assign usb_live  = usb_pending_next & usb_source_enable;
  assign fifo_live = fifo_pending_next & fifo_source_enable;

  iav_prio_enc #(
    .N (`IAV_USB_SLOTS),
    .W (`IAV_USB_SLOT_W)
  ) u_usb_enc (
    .req   (usb_live),
    .found (usb_found),
    .index (usb_top_slot)
  );

  iav_prio_enc #(
    .N (`IAV_FIFO_SLOTS),
    .W (`IAV_FIFO_SLOT_W)
  ) u_fifo_enc (
    .req   (fifo_live),
    .found (fifo_found),
    .index (fifo_top_slot)
  );

  // request lines follow the merged enabled pending bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      usb_int_request  <= 1'b0;
      fifo_int_request <= 1'b0;
    end else begin
      usb_int_request  <= usb_found;
      fifo_int_request <= fifo_found;
    end
  end

  // vector byte is the winning slot times four above the line base;
  // it holds its last value while nothing is pending
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      usb_vector_byte <= `IAV_VEC_RESET;
    end else if (usb_found) begin
      usb_vector_byte <= `IAV_USB_VEC_BASE | {1'b0, usb_top_slot, 2'b00};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fifo_vector_byte <= `IAV_VEC_RESET;
    end else if (fifo_found) begin
      fifo_vector_byte <= `IAV_FIFO_VEC_BASE | {2'b00, fifo_top_slot, 2'b00};
    end
  end

  // code fetch: the vector byte replaces stored memory at the page offset
  // location only; the page byte itself still comes from memory
  logic [7:0] fetch_data_next;

  always_comb begin
    fetch_data_next = mem_rdata;
    if (usb_autovector_enable && fetch_addr == `IAV_USB_VEC_ADDR) begin
      fetch_data_next = usb_vector_byte;
    end else if (fifo_autovector_enable && fetch_addr == `IAV_FIFO_VEC_ADDR) begin
      fetch_data_next = fifo_vector_byte;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fetch_data_valid <= 1'b0;
      fetch_data       <= `IAV_BYTE_RESET;
    end else begin
      fetch_data_valid <= fetch_valid;
      if (fetch_valid) begin
        fetch_data <= fetch_data_next;
      end
    end
  end

  // interrupt entry: push pc low then high, then branch to the line's slot.
  // usb is taken before fifo when both ask; no nesting until return.
  iav_pkg::iav_entry_t state_reg;
  iav_pkg::iav_entry_t state_next;
  iav_pkg::iav_line_t  line_reg;
  logic [15:0]         saved_pc_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      iav_pkg::ENTRY_IDLE: begin
        if (core_take_ok && (usb_int_request || fifo_int_request)) begin
          state_next = iav_pkg::ENTRY_PUSH_LO;
        end
      end
      iav_pkg::ENTRY_PUSH_LO: begin
        state_next = iav_pkg::ENTRY_PUSH_HI;
      end
      iav_pkg::ENTRY_PUSH_HI: begin
        state_next = iav_pkg::ENTRY_BRANCH;
      end
      iav_pkg::ENTRY_BRANCH: begin
        state_next = iav_pkg::ENTRY_SERVICE;
      end
      iav_pkg::ENTRY_SERVICE: begin
        if (core_reti) begin
          state_next = iav_pkg::ENTRY_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= iav_pkg::ENTRY_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // line choice and pc are caught when the entry starts
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_reg     <= iav_pkg::LINE_USB;
      saved_pc_reg <= `IAV_ADDR_RESET;
    end else if (state_reg == iav_pkg::ENTRY_IDLE && state_next == iav_pkg::ENTRY_PUSH_LO) begin
      line_reg     <= usb_int_request ? iav_pkg::LINE_USB : iav_pkg::LINE_FIFO;
      saved_pc_reg <= core_pc;
    end
  end

  // stack push strobes, one byte per cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stack_push      <= 1'b0;
      stack_push_byte <= `IAV_BYTE_RESET;
    end else begin
      stack_push <= 1'b0;
      if (state_next == iav_pkg::ENTRY_PUSH_LO) begin
        stack_push      <= 1'b1;
        stack_push_byte <= core_pc[7:0];
      end else if (state_next == iav_pkg::ENTRY_PUSH_HI) begin
        stack_push      <= 1'b1;
        stack_push_byte <= saved_pc_reg[15:8];
      end
    end
  end

  // branch after both pushes; target is the jump slot of the entered line
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      branch_valid  <= 1'b0;
      branch_target <= `IAV_ADDR_RESET;
    end else begin
      branch_valid <= 1'b0;
      if (state_next == iav_pkg::ENTRY_BRANCH) begin
        branch_valid <= 1'b1;
        if (line_reg == iav_pkg::LINE_USB) begin
          branch_target <= `IAV_USB_JUMP_ADDR;
        end else begin
          branch_target <= `IAV_FIFO_JUMP_ADDR;
        end
      end
    end
  end

  // service flag stays up until the core returns
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_service <= 1'b0;
    end else begin
      in_service <= (state_next != iav_pkg::ENTRY_IDLE);
    end
  end

endmodule : iav_autovector

`default_nettype wire

/* tb/iav_autovector_monitor.sv */
// Purpose: port checks of the autovector block
// Assumes: one clock, rst_n asynchronous active low
// Notes:   bound to every iav_autovector instance
`default_nettype none

module iav_autovector_monitor (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // inputs
  input wire logic        setup_data_available,
  input wire logic [31:0] usb_source_enable,
  input wire logic        usb_autovector_enable,
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0]  mem_rdata,
  input wire logic [15:0] core_pc,
  // outputs
  input wire logic        fetch_data_valid,
  input wire logic [7:0]  fetch_data,
  input wire logic        usb_int_request,
  input wire logic        fifo_int_request,
  input wire logic [7:0]  usb_vector_byte,
  input wire logic [31:0] usb_pending,
  input wire logic [13:0] fifo_pending,
  input wire logic        in_service,
  input wire logic        stack_push,
  input wire logic [7:0]  stack_push_byte,
  input wire logic        branch_valid,
  input wire logic [15:0] branch_target
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // low byte first, so the return pops the right way round
  sequence s_push;
    stack_push && stack_push_byte == 8'($past(core_pc)) ##1
    stack_push && stack_push_byte == 8'($past(core_pc, 2) >> 8) ##1
    !stack_push && branch_valid;
  endsequence

  chk_usb_merge: assert property (
    $rose(usb_int_request) |-> (usb_pending & usb_source_enable) != 32'h0)
    else $error("usb request without an enabled pending source");
  chk_sdav_vector: assert property (
    setup_data_available && usb_source_enable[0] |=> usb_pending[0] && usb_int_request && usb_vector_byte == 8'h00)
    else $error("setup data event did not give vector 00");
  chk_rsvd_slots: assert property (
    (usb_pending & 32'h0E02_0080) == 32'h0)
    else $error("reserved usb slot pending");
  chk_usb_subst: assert property (
    fetch_valid && fetch_addr == 16'h0045 && usb_autovector_enable |=> fetch_data_valid && fetch_data == $past(usb_vector_byte))
    else $error("usb vector not substituted");
  chk_page_pass: assert property (
    fetch_valid && fetch_addr inside {16'h0044, 16'h0054} |=> fetch_data_valid && fetch_data == $past(mem_rdata))
    else $error("page byte not passed from memory");
  chk_fifo_merge: assert property (
    $rose(fifo_int_request) |-> fifo_pending != 14'h0)
    else $error("fifo request without pending source");
  chk_usb_entry: assert property (
    $rose(in_service) && $past(usb_int_request) |-> s_push ##0 branch_target == 16'h0043)
    else $error("usb entry sequence wrong");
  chk_fifo_entry: assert property (
    $rose(in_service) && !$past(usb_int_request) && $past(fifo_int_request) |-> s_push ##0 branch_target == 16'h0053)
    else $error("fifo entry sequence wrong");
endmodule : iav_autovector_monitor

bind iav_autovector iav_autovector_monitor u_monitor (
  .clock, .rst_n, .setup_data_available, .usb_source_enable, .usb_autovector_enable, .fetch_valid,
  .fetch_addr, .mem_rdata, .core_pc, .fetch_data_valid, .fetch_data, .usb_int_request, .fifo_int_request,
  .usb_vector_byte, .usb_pending, .fifo_pending, .in_service, .stack_push, .stack_push_byte, .branch_valid,
  .branch_target);

`default_nettype wire

/* tb/iav_core_model.sv */
// Purpose: core and handler firmware facing the autovector block
// Assumes: memory answers in the fetch cycle
// Notes:   stall slows the handler start
`default_nettype none

module iav_core_model #(
  parameter logic [7:0] PAGE_U = 8'h3A,
  parameter logic [7:0] PAGE_F = 8'h3B
) (
  // clock and pacing
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [3:0]  stall,
  // from the block
  input wire logic        branch_valid,
  input wire logic [15:0] branch_target,
  input wire logic        fetch_data_valid,
  input wire logic [7:0]  fetch_data,
  // to the block
  output logic            fetch_valid,
  output logic [15:0]     fetch_addr,
  output logic [7:0]      mem_rdata,
  output logic            core_take_ok,
  output logic [15:0]     core_pc,
  output logic            core_reti,
  output logic            usb_clear,
  output logic [4:0]      usb_clear_slot,
  output logic            fifo_clear,
  output logic [3:0]      fifo_clear_slot,
  // handler results
  output logic [15:0]     jump_addr,
  output logic [7:0]      n_entries
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] base;
  logic [7:0]  hi;
  logic [7:0]  lo;

  function automatic logic [7:0] code_byte(input logic [15:0] a);
    case (a)
      16'h0044: code_byte = PAGE_U;
      16'h0054: code_byte = PAGE_F;
      default:  code_byte = 8'h5A;
    endcase
  endfunction : code_byte

  // idle bus shows the inverse, never a stale byte
  assign mem_rdata = fetch_valid ? code_byte(fetch_addr) : ~code_byte(fetch_addr);

  task automatic rd(input logic [15:0] a, output logic [7:0] b);
    @(negedge clock);
    fetch_valid = 1'b1;
    fetch_addr  = a;
    @(negedge clock);
    fetch_valid = 1'b0;
    b = fetch_data_valid ? fetch_data : 8'hEE;
  endtask : rd

  initial begin
    {fetch_valid, core_reti, usb_clear, fifo_clear} = 4'h0;
    {fetch_addr, jump_addr, usb_clear_slot, fifo_clear_slot, n_entries} = '0;
    core_take_ok = 1'b1;
    core_pc      = 16'hC3A5;
    forever begin
      @(negedge clock);
      if (rst_n && branch_valid) begin
        base = branch_target;
        repeat (stall) @(negedge clock);
        rd(base + 16'h1, hi);
        rd(base + 16'h2, lo);
        jump_addr       = {hi, lo};
        usb_clear       = (base == 16'h0043);
        fifo_clear      = !usb_clear;
        usb_clear_slot  = lo[6:2];
        fifo_clear_slot = lo[5:2];
        @(negedge clock);
        {usb_clear, fifo_clear} = 2'b00;
        core_reti = 1'b1;
        @(negedge clock);
        core_reti = 1'b0;
        n_entries++;
      end
    end
  end
endmodule : iav_core_model

`default_nettype wire

/* tb/usb_fifo_interrupt_autovector_test.sv */
// Purpose: self-checking bench of the autovector block
// Assumes: core model runs handlers and clears sources
// Notes:   inputs change at the falling edge
`default_nettype none

module usb_fifo_interrupt_autovector_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PAGE_U = 8'h3A;
  localparam logic [7:0] PAGE_F = 8'h3B;
  logic        clock, rst_n, usb_av, fifo_av, usb_req, fetch_valid, fetch_data_valid;
  logic        core_take_ok, core_reti, usb_clear, fifo_clear, branch_valid;
  logic [31:0] usb_ev, usb_en, usb_pending;
  logic [13:0] fifo_ev;
  logic [15:0] fetch_addr, core_pc, branch_target, jump_addr;
  logic [7:0]  mem_rdata, fetch_data, n_entries, seen;
  logic [4:0]  usb_clear_slot;
  logic [3:0]  fifo_clear_slot, stall;
  int          n_errors, check_count;

  iav_autovector dut (
    .clock, .rst_n, .setup_data_available(usb_ev[0]), .start_of_frame(usb_ev[1]), .setup_token_seen(usb_ev[2]),
    .usb_suspend(usb_ev[3]), .usb_bus_reset(usb_ev[4]), .high_speed_entered(usb_ev[5]),
    .control_handshake_acked(usb_ev[6]), .ep0_in_ready(usb_ev[8]), .ep0_out_data(usb_ev[9]),
    .ep1_in_ready(usb_ev[10]), .ep1_out_data(usb_ev[11]), .ep_buffer_event(usb_ev[15:12]),
    .in_bulk_nak(usb_ev[16]), .ep_ping_nak(usb_ev[23:18]), .bus_error_limit(usb_ev[24]),
    .ep_iso_pid_error(usb_ev[31:28]), .ep_prog_level_flag(fifo_ev[3:0]), .ep_empty_flag(fifo_ev[7:4]),
    .ep_full_flag(fifo_ev[11:8]), .waveform_op_complete(fifo_ev[12]), .waveform_event(fifo_ev[13]),
    .usb_autovector_enable(usb_av), .fifo_autovector_enable(fifo_av), .usb_source_enable(usb_en),
    .fifo_source_enable(14'h3FFF), .usb_clear, .usb_clear_slot, .fifo_clear, .fifo_clear_slot, .fetch_valid,
    .fetch_addr, .mem_rdata, .fetch_data_valid, .fetch_data, .core_take_ok, .core_pc, .core_reti,
    .stack_push(), .stack_push_byte(), .branch_valid, .branch_target, .in_service(), .usb_int_request(usb_req),
    .fifo_int_request(), .usb_vector_byte(), .fifo_vector_byte(), .usb_pending, .fifo_pending());

  iav_core_model #(.PAGE_U(PAGE_U), .PAGE_F(PAGE_F)) core (
    .clock, .rst_n, .stall, .branch_valid, .branch_target, .fetch_data_valid, .fetch_data, .fetch_valid,
    .fetch_addr, .mem_rdata, .core_take_ok, .core_pc, .core_reti, .usb_clear, .usb_clear_slot, .fifo_clear,
    .fifo_clear_slot, .jump_addr, .n_entries);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic fire(input logic [31:0] u, input logic [13:0] f);
    @(negedge clock);
    usb_ev  = u;
    fifo_ev = f;
    @(negedge clock);
    usb_ev  = 32'h0;
    fifo_ev = f & 14'h0FFF; // flags stay as levels
  endtask : fire

  task automatic expect_jump(input logic [15:0] exp);
    for (int i = 0; i < 300 && n_entries === seen; i++) @(negedge clock);
    seen = n_entries;
    check(jump_addr, exp);
  endtask : expect_jump

  task automatic t_usb_table;
    usb_av = 1'b1;
    for (int n = 0; n < 32; n++) begin
      if (n inside {7, 17, 25, 26, 27}) continue;
      fire(32'h1 << n, 14'h0);
      expect_jump({PAGE_U, 8'(n * 4)});
    end
    $display("usb table done");
  endtask : t_usb_table

  task automatic t_fifo_table;
    fifo_av = 1'b1;
    stall   = 4'h5;
    for (int n = 0; n < 14; n++) begin
      fire(32'h0, 14'h1 << n);
      expect_jump({PAGE_F, 8'h80 + 8'(n * 4)});
      fifo_ev = 14'h0;
    end
    stall = 4'h0;
    $display("fifo table done");
  endtask : t_fifo_table

  task automatic t_priority;
    fire(32'h1000_0208, 14'h0);
    expect_jump({PAGE_U, 8'h0C});
    expect_jump({PAGE_U, 8'h24});
    expect_jump({PAGE_U, 8'h70});
    fire(32'h20, 14'h2000);
    expect_jump({PAGE_U, 8'h14});
    expect_jump({PAGE_F, 8'hB4});
    $display("priority done");
  endtask : t_priority

  task automatic t_no_subst;
    // stored byte 5A also names slot 22, so the handler clears the right source
    usb_av = 1'b0;
    fire(32'h1 << 22, 14'h0);
    expect_jump({PAGE_U, 8'h5A});
    // on the fifo line 5A names slot 6, the ep6 empty flag
    fifo_av = 1'b0;
    fire(32'h0, 14'h0040);
    expect_jump({PAGE_F, 8'h5A});
    fifo_ev = 14'h0;
    fifo_av = 1'b1;
    usb_av = 1'b1;
    usb_en = ~32'h2;
    fire(32'h2, 14'h0);
    repeat (4) @(negedge clock);
    check({14'h0, usb_req, usb_pending[1]}, 16'h1);
    usb_en = '1;
    expect_jump({PAGE_U, 8'h04});
    $display("substitution off and gating done");
  endtask : t_no_subst

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  initial begin
    {rst_n, usb_av, fifo_av, usb_ev, fifo_ev, stall, seen} = '0;
    usb_en = '1;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    t_usb_table();
    t_fifo_table();
    t_priority();
    t_no_subst();
    wrap_up();
  end

  initial begin
    repeat (6000) @(posedge clock);
    n_errors++;
    wrap_up();
  end
endmodule : usb_fifo_interrupt_autovector_test

`default_nettype wire
